// ==== psc_host_model.sv ====
// Purpose: External 8-bit bus master that strobes the slave port pins
// Assumes: Pins change just after a rising clk edge, held many cycles
// Notes:   Released data lines show the inverse of the last byte
`default_nettype none
`timescale 1ns/1ps
module psc_host_model (
  input  wire logic       clk,
  input  wire logic [7:0] data_bus,
  output var  logic [2:0] pins_n,
  output var  logic [7:0] data_drv
);
  initial pins_n = 3'h7;
  initial data_drv = 8'h00;

  task automatic hold(input int n);
    repeat (n) @(posedge clk);
  endtask

  // Byte stays on the lines well past the strobe rise for the synchroniser
  task automatic put(input logic [7:0] b);
    @(posedge clk);
    data_drv <= b;
    pins_n <= 3'h1;
    hold(5);
    pins_n <= 3'h7;
    hold(4);
    data_drv <= ~b;
    hold(2);
  endtask

  task automatic get(output logic [7:0] b);
    @(posedge clk);
    pins_n <= 3'h2;
    hold(6);
    b = data_bus;
    pins_n <= 3'h7;
    hold(5);
  endtask
endmodule
`default_nettype wire

// ==== psc_irq.sv ====
// Purpose: Sticky interrupt status with mask and one level output
// Assumes: Events are one-cycle pulses on clk
// Notes:   Write one to clear; an event in the clearing cycle wins
`default_nettype none
`timescale 1ns/1ps
module psc_irq #(
  parameter int unsigned W = 2
) (
  input  wire logic         clk,
  input  wire logic         rstn,
  input  wire logic [W-1:0] ev,
  input  wire logic         wr_stat,
  input  wire logic         wr_mask,
  input  wire logic [W-1:0] wdata,
  output logic      [W-1:0] stat_q,
  output logic      [W-1:0] mask_q,
  output logic              irq_q
);
  always_ff @(posedge clk or negedge rstn)
  begin
    if (!rstn)
      stat_q <= '0;
    else
      stat_q <= (stat_q & ~(wr_stat ? wdata : '0)) | ev;
  end

  always_ff @(posedge clk or negedge rstn)
  begin
    if (!rstn)
      mask_q <= '0;
    else if (wr_mask)
      mask_q <= wdata;
  end

  always_ff @(posedge clk or negedge rstn)
  begin
    if (!rstn)
      irq_q <= 1'b0;
    else
      irq_q <= |(stat_q & mask_q);
  end
endmodule
`default_nettype wire

// ==== psc_pkg.sv ====
// Purpose: Shared constants for the parallel slave port control block
// Assumes: APB slave with 32-bit data, one aligned word per register
// Notes:   Byte offsets, field positions and reset values live here
`default_nettype none
package psc_pkg;
  localparam int unsigned ADDR_W = 8;
  localparam int unsigned DATA_W = 32;
  localparam int unsigned PIN_W  = 3;
  localparam int unsigned BYTE_W = 8;
  localparam int unsigned IRQ_W  = 2;

  // Register byte offsets
  localparam logic [7:0] OFF_CTRL   = 8'h00;
  localparam logic [7:0] OFF_LATCH  = 8'h04;
  localparam logic [7:0] OFF_PORTIN = 8'h08;
  localparam logic [7:0] OFF_DATA   = 8'h0C;
  localparam logic [7:0] OFF_ANALOG = 8'h10;
  localparam logic [7:0] OFF_ISTAT  = 8'h14;
  localparam logic [7:0] OFF_IMASK  = 8'h18;

  // Fields of control_port_direction_status
  localparam int unsigned BIT_IBF  = 7;
  localparam int unsigned BIT_OBF  = 6;
  localparam int unsigned BIT_OVF  = 5;
  localparam int unsigned BIT_MODE = 4;
  localparam int unsigned BIT_DIRH = 2;

  // Interrupt status bits
  localparam int unsigned IRQ_PORT = 0;
  localparam int unsigned IRQ_OVF  = 1;

  // Roles of the three control pins in slave mode
  localparam int unsigned PIN_RD = 0;
  localparam int unsigned PIN_WR = 1;
  localparam int unsigned PIN_CS = 2;

  // Values after reset
  localparam logic [2:0] RST_DIR    = 3'h7;
  localparam logic [2:0] RST_ANALOG = 3'h7;
  localparam logic [2:0] RST_LATCH  = 3'h0;
  localparam logic [7:0] RST_BYTE   = 8'h00;
  localparam logic [1:0] RST_IRQ    = 2'h0;
endpackage
`default_nettype wire

// ==== psc_sync.sv ====
// Purpose: Two-flop synchroniser for a group of pin inputs
// Assumes: Inputs asynchronous to clk
// Notes:   First stage is read only by the second stage
`default_nettype none
`timescale 1ns/1ps
module psc_sync #(
  parameter int unsigned W = 1,
  parameter logic [W-1:0] RST = '0
) (
  input  wire logic         clk,
  input  wire logic         rstn,
  input  wire logic [W-1:0] d,
  output logic      [W-1:0] q
);
  logic [W-1:0] meta_q;

  always_ff @(posedge clk or negedge rstn)
  begin
    if (!rstn)
    begin
      meta_q <= RST;
      q      <= RST;
    end
    else
    begin
      meta_q <= d;
      q      <= meta_q;
    end
  end
endmodule
`default_nettype wire

// ==== psc_tb_top.sv ====
// Purpose: Self-checking bench for the slave port control block
// Assumes: APB master and external bus master share the 10 MHz clock
// Notes:   Expected values come from the register layout, not the design
`default_nettype none
`timescale 1ns/1ps
module psc_tb_top;
  logic        clk = 1'h0;
  logic        rstn = 1'h0;
  logic        psel = 1'h0;
  logic        penable = 1'h0;
  logic        pwrite = 1'h0;
  logic [7:0]  paddr = 8'h00;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata;
  logic        pready;
  logic        pslverr;
  logic        pwm_multi_out = 1'h0;
  logic [2:0]  pins_n;
  logic [2:0]  pin_out;
  logic [2:0]  pin_oe;
  logic [7:0]  data_drv;
  logic [7:0]  dout;
  logic        doe;
  logic        irq;
  wire  [7:0]  data_bus = doe ? dout : data_drv;
  logic [31:0] rdata;
  logic        serr;
  logic [7:0]  b;
  int          num_errors = 0;
  int          compares = 0;

  always #50 clk = ~clk;

  psc_top i_dut (
    .clk(clk), .rstn(rstn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .pwm_multi_out(pwm_multi_out),
    .control_pin_in(pins_n), .control_pin_out(pin_out),
    .control_pin_oe(pin_oe), .slave_data_port_in(data_bus),
    .slave_data_port_out(dout), .slave_data_port_oe(doe), .irq(irq)
  );

  psc_host_model i_host (
    .clk(clk), .data_bus(data_bus), .pins_n(pins_n), .data_drv(data_drv)
  );

  task automatic finish_test;
    $display("compares %0d errors %0d", compares, num_errors);
    if (num_errors == 0 && compares > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask

  task automatic chk(input string nm, input logic [31:0] e,
                     input logic [31:0] g);
    compares++;
    if (g !== e)
    begin
      num_errors++;
      $display("mismatch %s expected %h seen %h", nm, e, g);
    end
  endtask

  // Request held until pready is sampled high; no latency assumed
  task automatic apb(input logic w, input logic [7:0] a,
                     input logic [31:0] d);
    @(posedge clk);
    psel <= 1'h1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'h1;
    // Only the watchdog ends a wait that never sees pready
    do
    begin
      @(posedge clk);
    end
    while (pready !== 1'h1);
    rdata = prdata;
    serr = pslverr;
    psel <= 1'h0;
    penable <= 1'h0;
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    apb(1'h1, a, d);
  endtask

  task automatic rd(input string nm, input logic [7:0] a,
                    input logic [31:0] e);
    apb(1'h0, a, 32'h0);
    chk(nm, e, rdata);
  endtask

  task automatic t_reset;
    rd("ctrl", psc_pkg::OFF_CTRL, 32'h07);
    rd("analog", psc_pkg::OFF_ANALOG, 32'h07);
    rd("portin", psc_pkg::OFF_PORTIN, 32'h00);
    chk("oe", 32'h0, {29'h0, pin_oe});
    rd("unmapped", 8'h1C, 32'h0);
    chk("slverr", 32'h1, {31'h0, serr});
  endtask

  task automatic t_access;
    wr(psc_pkg::OFF_CTRL, 32'hFF);
    rd("ctrl", psc_pkg::OFF_CTRL, 32'h37);
    wr(psc_pkg::OFF_LATCH, 32'h05);
    wr(psc_pkg::OFF_CTRL, 32'h30);
    // Direction lands at the completion edge, the pin enable one edge later
    repeat (2) @(posedge clk);
    chk("pin oe", 32'h7, {29'h0, pin_oe});
    chk("pin out", 32'h5, {29'h0, pin_out});
    wr(psc_pkg::OFF_CTRL, 32'h07);
    rd("ctrl", psc_pkg::OFF_CTRL, 32'h07);
    wr(psc_pkg::OFF_ANALOG, 32'h0);
    rd("portin", psc_pkg::OFF_PORTIN, 32'h07);
  endtask

  // Strobes must be ignored outside slave mode and under multi-output PWM
  task automatic t_blocked;
    i_host.put(8'h11);
    rd("ctrl", psc_pkg::OFF_CTRL, 32'h07);
    wr(psc_pkg::OFF_CTRL, 32'h17);
    @(posedge clk);
    pwm_multi_out <= 1'h1;
    i_host.put(8'h22);
    rd("ctrl", psc_pkg::OFF_CTRL, 32'h17);
    @(posedge clk);
    pwm_multi_out <= 1'h0;
  endtask

  task automatic t_slave_write;
    wr(psc_pkg::OFF_IMASK, 32'h3);
    i_host.put(8'hA5);
    rd("ctrl", psc_pkg::OFF_CTRL, 32'h97);
    chk("irq", 32'h1, {31'h0, irq});
    i_host.put(8'h5A);
    rd("ctrl", psc_pkg::OFF_CTRL, 32'hB7);
    rd("istat", psc_pkg::OFF_ISTAT, 32'h3);
    rd("data", psc_pkg::OFF_DATA, 32'hA5);
    rd("ctrl", psc_pkg::OFF_CTRL, 32'h37);
    wr(psc_pkg::OFF_ISTAT, 32'h3);
    rd("istat", psc_pkg::OFF_ISTAT, 32'h0);
    chk("irq", 32'h0, {31'h0, irq});
    wr(psc_pkg::OFF_CTRL, 32'h17);
  endtask

  task automatic t_slave_read;
    wr(psc_pkg::OFF_DATA, 32'h3C);
    rd("ctrl", psc_pkg::OFF_CTRL, 32'h57);
    i_host.get(b);
    chk("read byte", 32'h3C, {24'h0, b});
    rd("ctrl", psc_pkg::OFF_CTRL, 32'h17);
    chk("data oe", 32'h0, {31'h0, doe});
    rd("istat", psc_pkg::OFF_ISTAT, 32'h1);
  endtask

  initial
  begin
    repeat (16) @(posedge clk);
    rstn <= 1'h1;
    t_reset();
    t_access();
    t_blocked();
    t_slave_write();
    t_slave_read();
    finish_test();
  end

  // Whole run is under two hundred cycles; this limit only catches a hang
  initial
  begin
    repeat (20000) @(posedge clk);
    num_errors++;
    finish_test();
  end
endmodule
`default_nettype wire

// ==== psc_top.sv ====
// Purpose: Control and status of an 8-bit parallel slave port
// Assumes: 10 MHz clk, APB register access, pins asynchronous
// Notes:   Strobes are seen one to two clocks after the pins move
// What this block does
// - Input-full is set by an unread external write, cleared when read.
// - Output-full stays set until the external master reads the byte.
// - Overflow sets on a write over an unread byte; only software clears.
// - Slave mode bit 1 gives the slave port, 0 gives general I/O.
// - A direction bit of 1 means input, 0 output; all reset to 1.
// - Bit 3 reads zero, full flags read-only, overflow and mode writable.
// - An output pin is driven from its latch even if set analog.
// - An input pin reaches the input register only when digital.
// - In slave mode pin 0 is the active-low read strobe.
// - In slave mode pin 1 is the active-low write strobe.
// - In slave mode pin 2 is the active-low chip select.
// - Control pins reset to analog channels five to seven.
// - A write ends when select or strobe rises, setting port and full flags.
// - Select and read low drive the data latch out and clear output-full.
// - Select or read high releases the data pins and sets the port flag.
// - Slave mode acts only while the PWM unit is not in multi-output mode.
//
// The APB register port and the register offsets are this design's own decisions.
`default_nettype none
`timescale 1ns/1ps
module psc_top (
  input  wire logic                        clk,
  input  wire logic                        rstn,
  input  wire logic                        psel,
  input  wire logic                        penable,
  input  wire logic                        pwrite,
  input  wire logic [psc_pkg::ADDR_W-1:0]  paddr,
  input  wire logic [psc_pkg::DATA_W-1:0]  pwdata,
  output logic      [psc_pkg::DATA_W-1:0]  prdata,
  output logic                             pready,
  output logic                             pslverr,
  input  wire logic                        pwm_multi_out,
  input  wire logic [psc_pkg::PIN_W-1:0]   control_pin_in,
  output logic      [psc_pkg::PIN_W-1:0]   control_pin_out,
  output logic      [psc_pkg::PIN_W-1:0]   control_pin_oe,
  input  wire logic [psc_pkg::BYTE_W-1:0]  slave_data_port_in,
  output logic      [psc_pkg::BYTE_W-1:0]  slave_data_port_out,
  output logic                             slave_data_port_oe,
  output logic                             irq
);
  logic [2:0] dir_q;
  logic [2:0] analog_q;
  logic [2:0] latch_q;
  logic [2:0] port_in_q;
  logic       mode_q;
  logic       ibf_q;
  logic       obf_q;
  logic       ovf_q;
  logic [7:0] in_buf_q;
  logic [7:0] out_byte_q;
  logic [2:0] pin_s;
  logic [7:0] data_s;
  logic       rd_act;
  logic       wr_act;
  logic       rd_act_q;
  logic       wr_act_q;
  logic       slave_on;
  logic       strobes_ok;
  logic       wr_end;
  logic       rd_start;
  logic       rd_end;
  logic       acc;
  logic       wr;
  logic       rd;
  logic [7:0] ctrl_rd;
  logic [1:0] istat;
  logic [1:0] imask;
  logic [31:0] rdata;
  logic        mapped;

  psc_sync #(.W(psc_pkg::PIN_W), .RST(3'h7)) u_sync_pin (
    .clk  (clk),
    .rstn (rstn),
    .d    (control_pin_in),
    .q    (pin_s)
  );

  psc_sync #(.W(psc_pkg::BYTE_W), .RST(8'h00)) u_sync_data (
    .clk  (clk),
    .rstn (rstn),
    .d    (slave_data_port_in),
    .q    (data_s)
  );

  // Mode bit is stored as written but gated by the PWM state
  assign slave_on   = mode_q & ~pwm_multi_out;
  // Strobes only count once pins are digital inputs
  assign strobes_ok = slave_on & (&dir_q) & ~(|analog_q);
  assign rd_act = strobes_ok & ~pin_s[psc_pkg::PIN_CS]
                  & ~pin_s[psc_pkg::PIN_RD];
  assign wr_act = strobes_ok & ~pin_s[psc_pkg::PIN_CS]
                  & ~pin_s[psc_pkg::PIN_WR];
  assign wr_end   = wr_act_q & ~wr_act;
  assign rd_start = rd_act & ~rd_act_q;
  assign rd_end   = rd_act_q & ~rd_act;

  always_ff @(posedge clk or negedge rstn)
  begin
    if (!rstn)
    begin
      rd_act_q <= 1'b0;
      wr_act_q <= 1'b0;
    end
    else
    begin
      rd_act_q <= rd_act;
      wr_act_q <= wr_act;
    end
  end

  // APB: one wait state, then the access completes
  assign acc = psel & penable & pready;
  assign wr  = acc & pwrite;
  assign rd  = acc & ~pwrite;

  always_comb
  begin
    mapped = 1'b1;
    rdata  = 32'h0000_0000;
    unique case (paddr)
      psc_pkg::OFF_CTRL:   rdata[7:0] = ctrl_rd;
      psc_pkg::OFF_LATCH:  rdata[2:0] = latch_q;
      psc_pkg::OFF_PORTIN: rdata[2:0] = port_in_q;
      psc_pkg::OFF_DATA:   rdata[7:0] = in_buf_q;
      psc_pkg::OFF_ANALOG: rdata[2:0] = analog_q;
      psc_pkg::OFF_ISTAT:  rdata[1:0] = istat;
      psc_pkg::OFF_IMASK:  rdata[1:0] = imask;
      default:             mapped     = 1'b0;
    endcase
  end

  assign ctrl_rd = {ibf_q, obf_q, ovf_q, mode_q, 1'b0, dir_q};

  always_ff @(posedge clk or negedge rstn)
  begin
    if (!rstn)
    begin
      pready  <= 1'b0;
      pslverr <= 1'b0;
      prdata  <= 32'h0000_0000;
    end
    else
    begin
      pready  <= psel & penable & ~pready;
      pslverr <= psel & penable & ~pready & ~mapped;
      if (psel & penable & ~pready & ~pwrite)
        prdata <= rdata;
    end
  end

  always_ff @(posedge clk or negedge rstn)
  begin
    if (!rstn)
    begin
      mode_q   <= 1'b0;
      dir_q    <= psc_pkg::RST_DIR;
      analog_q <= psc_pkg::RST_ANALOG;
      latch_q  <= psc_pkg::RST_LATCH;
    end
    else if (wr)
    begin
      if (paddr == psc_pkg::OFF_CTRL)
      begin
        mode_q <= pwdata[psc_pkg::BIT_MODE];
        dir_q  <= pwdata[psc_pkg::BIT_DIRH:0];
      end
      if (paddr == psc_pkg::OFF_ANALOG)
        analog_q <= pwdata[2:0];
      if (paddr == psc_pkg::OFF_LATCH)
        latch_q <= pwdata[2:0];
    end
  end

  // Receive side; an overflowing byte is dropped, the unread one kept
  always_ff @(posedge clk or negedge rstn)
  begin
    if (!rstn)
    begin
      ibf_q    <= 1'b0;
      in_buf_q <= psc_pkg::RST_BYTE;
    end
    else if (wr_end)
    begin
      ibf_q <= 1'b1;
      if (!ibf_q)
        in_buf_q <= data_s;
    end
    else if (rd && paddr == psc_pkg::OFF_DATA)
      ibf_q <= 1'b0;
  end

  always_ff @(posedge clk or negedge rstn)
  begin
    if (!rstn)
      ovf_q <= 1'b0;
    else if (wr_end && ibf_q)
      ovf_q <= 1'b1;
    else if (wr && paddr == psc_pkg::OFF_CTRL)
      ovf_q <= pwdata[psc_pkg::BIT_OVF];
  end

  // A CPU write during an active read goes out at once, flag stays clear
  always_ff @(posedge clk or negedge rstn)
  begin
    if (!rstn)
    begin
      obf_q      <= 1'b0;
      out_byte_q <= psc_pkg::RST_BYTE;
    end
    else
    begin
      if (wr && paddr == psc_pkg::OFF_DATA)
        out_byte_q <= pwdata[7:0];
      if (rd_start)
        obf_q <= 1'b0;
      else if (wr && paddr == psc_pkg::OFF_DATA && !rd_act)
        obf_q <= 1'b1;
    end
  end

  always_ff @(posedge clk or negedge rstn)
  begin
    if (!rstn)
    begin
      slave_data_port_oe  <= 1'b0;
      slave_data_port_out <= psc_pkg::RST_BYTE;
    end
    else
    begin
      slave_data_port_oe  <= rd_act;
      slave_data_port_out <= (wr && paddr == psc_pkg::OFF_DATA) ?
                             pwdata[7:0] : out_byte_q;
    end
  end

  always_ff @(posedge clk or negedge rstn)
  begin
    if (!rstn)
    begin
      control_pin_oe  <= 3'h0;
      control_pin_out <= psc_pkg::RST_LATCH;
      port_in_q       <= 3'h0;
    end
    else
    begin
      control_pin_oe  <= ~dir_q;
      control_pin_out <= latch_q;
      port_in_q       <= pin_s & dir_q & ~analog_q;
    end
  end

  psc_irq #(.W(psc_pkg::IRQ_W)) u_irq (
    .clk     (clk),
    .rstn    (rstn),
    .ev      ({wr_end & ibf_q, wr_end | rd_end}),
    .wr_stat (wr && paddr == psc_pkg::OFF_ISTAT),
    .wr_mask (wr && paddr == psc_pkg::OFF_IMASK),
    .wdata   (pwdata[1:0]),
    .stat_q  (istat),
    .mask_q  (imask),
    .irq_q   (irq)
  );

  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!rstn);

  property p_ibf_set;
    wr_end |=> ibf_q && istat[psc_pkg::IRQ_PORT];
  endproperty
  a_ibf_set: assert property (p_ibf_set)
    else $error("write end did not set full and port flags");

  property p_ovf_set;
    wr_end && ibf_q |=> ovf_q && $stable(in_buf_q);
  endproperty
  a_ovf_set: assert property (p_ovf_set)
    else $error("overflow not flagged or buffer overwritten");

  property p_ovf_hold;
    ovf_q && !(wr && paddr == psc_pkg::OFF_CTRL) |=> ovf_q;
  endproperty
  a_ovf_hold: assert property (p_ovf_hold)
    else $error("overflow cleared without software");

  property p_obf_clr;
    rd_start |=> !obf_q ##1 slave_data_port_oe;
  endproperty
  a_obf_clr: assert property (p_obf_clr)
    else $error("read start did not clear flag and drive");

  property p_rd_release;
    rd_end |=> !slave_data_port_oe && istat[psc_pkg::IRQ_PORT];
  endproperty
  a_rd_release: assert property (p_rd_release)
    else $error("read end did not release pins or flag");

  property p_gpio;
    !slave_on |=> !slave_data_port_oe;
  endproperty
  a_gpio: assert property (p_gpio)
    else $error("data pins driven outside slave mode");

  property p_pwm_block;
    pwm_multi_out |-> !rd_act && !wr_act;
  endproperty
  a_pwm_block: assert property (p_pwm_block)
    else $error("strobe seen while PWM owns the port");

  property p_dir;
    $changed(dir_q) |=> control_pin_oe == ~$past(dir_q);
  endproperty
  a_dir: assert property (p_dir)
    else $error("pin enable does not follow direction");

  property p_analog_in;
    ##1 (port_in_q & $past(analog_q)) == 3'h0;
  endproperty
  a_analog_in: assert property (p_analog_in)
    else $error("analog pin leaked into input register");

  property p_bit3;
    rd && paddr == psc_pkg::OFF_CTRL |-> !prdata[3];
  endproperty
  a_bit3: assert property (p_bit3)
    else $error("unimplemented bit read as one");

  c_write: cover property (wr_act ##[1:20] wr_end);
  c_read: cover property (rd_start ##[1:20] rd_end);
  c_ovf: cover property (wr_end && ibf_q);
  c_irq: cover property ($rose(irq));
endmodule
`default_nettype wire
